// >>> hdl/logging_session_control_regs.svh
// register offsets, reset values and timing counts of the session controller
`ifndef LOGGING_SESSION_CONTROL_REGS_SVH
`define LOGGING_SESSION_CONTROL_REGS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define OFS_CONFIG 12'h000
`define OFS_COMMAND 12'h004
`define OFS_START_LEVEL 12'h008
`define OFS_STOP_LEVEL 12'h00C
`define OFS_SAMPLE_LIMIT 12'h010
`define OFS_TIME_LIMIT 12'h014
`define OFS_PERIOD_LIMIT 12'h018
`define OFS_CAPTURE_TIME 12'h01C
`define OFS_REST_TIME 12'h020
`define OFS_EXTENSION 12'h024
`define OFS_STATUS 12'h028
`define OFS_SAMPLES 12'h02C
`define OFS_ELAPSED 12'h030
`define OFS_FOLDER 12'h034

// ---------------------------------------------------------------
// config fields
// ---------------------------------------------------------------
`define CFG_START_LSB 0
`define CFG_STOP_LSB 4
`define CFG_PATTERN_BIT 8

// ---------------------------------------------------------------
// command codes
// ---------------------------------------------------------------
`define CMD_MASS_STORAGE_OFF 8'h3A
`define CMD_FORMAT_CARD 8'h3B
`define CMD_START_SESSION 8'h3C
`define CMD_STOP_SESSION 8'h3D

// ---------------------------------------------------------------
// reset values: left button start, right button stop
// ---------------------------------------------------------------
`define RST_CONFIG 32'h0000_0032
`define RST_START_LEVEL 32'h0000_01F4
`define RST_STOP_LEVEL 32'h0000_012C
`define RST_SAMPLE_LIMIT 32'h0000_0064
`define RST_TIME_LIMIT 32'h0000_1388
`define RST_PERIOD_LIMIT 32'h0000_0001
`define RST_CAPTURE_TIME 32'h0000_1388
`define RST_REST_TIME 32'h0000_1388
`define RST_EXTENSION 32'h0000_0000

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLK_HZ 100000000
`define MS_PERIOD_MS 1
`define MS_CYCLES ((`CLK_HZ / 1000) * `MS_PERIOD_MS)

`endif

// >>> hdl/logging_session_pkg.sv
// types shared by the session controller
package logging_session_pkg;

  typedef enum logic [3:0] {
    start_command,
    start_power_up,
    start_left,
    start_right,
    start_both,
    start_motion
  } start_source_e;

  typedef enum logic [3:0] {
    stop_command,
    stop_immediate,
    stop_left,
    stop_right,
    stop_both,
    stop_motion,
    stop_samples,
    stop_duration,
    stop_periods
  } stop_source_e;

  typedef struct packed {
    logic sample_tick;
    logic [15:0] motion_mg;
  } motion_sample_s;

  typedef struct packed {
    logic card_present;
    logic init_done;
    logic init_ok;
    logic card_formatted;
  } card_status_s;

  typedef struct packed {
    logic red_pulse;
    logic blue_steady;
  } indicator_s;

endpackage

// >>> hdl/logging_session_control.sv
// session control for the data logger, with its ahb-lite register slave
`timescale 1ns/1ps
`include "logging_session_control_regs.svh"

module logging_session_control #(
  parameter int unsigned MS_CYCLES = `MS_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // pins from outside
  input wire logic usb_attached,
  input wire logic button_left,
  input wire logic button_right,
  // card controller and sampler, same clock
  input wire logging_session_pkg::card_status_s card_status,
  input wire logging_session_pkg::motion_sample_s motion,
  // outputs
  output logic card_to_host,
  output logic card_init_req,
  output logic card_format_req,
  output logic folder_create_req,
  output logic recording,
  output logic session_active,
  output logging_session_pkg::indicator_s indicator
);
  import logging_session_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
    end else begin
      sync_a <= {usb_attached, button_right, button_left};
      sync_b <= sync_a;
    end
  end
  wire logic usb_s = sync_b[2];
  wire logic [1:0] btn = sync_b[1:0];

  // ---------------------------------------------------------------
  // registers and bus
  // ---------------------------------------------------------------
  logic [31:0] config_reg, start_level, stop_level, sample_limit;
  logic [31:0] time_limit, period_limit, capture_time, rest_time;
  logic [31:0] extension;
  logic [31:0] samples, elapsed, periods, folder_stamp, uptime_ms;
  logic [31:0] ms_div;
  logic [31:0] phase_ms, ext_ms;
  logic wr_pend;
  logic [11:0] wr_addr;
  logic cmd_pulse;
  logic [7:0] cmd_code;
  logic host_owns, mass_off, card_ready, in_extension, in_rest;
  logic power_up_done, stop_armed, usb_prev, present_prev;
  logic [1:0] btn_prev;
  logic ms_tick;

  start_source_e start_src;
  stop_source_e stop_src;
  assign start_src = start_source_e'(config_reg[`CFG_START_LSB +: 4]);
  assign stop_src = stop_source_e'(config_reg[`CFG_STOP_LSB +: 4]);
  wire logic periodic = config_reg[`CFG_PATTERN_BIT];

  wire logic addr_phase = hsel & htrans[1] & hready;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_pend <= 1'b0;
      wr_addr <= 12'h000;
    end else begin
      wr_pend <= addr_phase & hwrite;
      wr_addr <= haddr;
    end
  end

  // writes land in the data phase, one cycle after the address phase
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      config_reg <= `RST_CONFIG;
      start_level <= `RST_START_LEVEL;
      stop_level <= `RST_STOP_LEVEL;
      sample_limit <= `RST_SAMPLE_LIMIT;
      time_limit <= `RST_TIME_LIMIT;
      period_limit <= `RST_PERIOD_LIMIT;
      capture_time <= `RST_CAPTURE_TIME;
      rest_time <= `RST_REST_TIME;
      extension <= `RST_EXTENSION;
      cmd_pulse <= 1'b0;
      cmd_code <= 8'h00;
    end else begin
      cmd_pulse <= 1'b0;
      if (wr_pend) begin
        case (wr_addr)
          `OFS_CONFIG: config_reg <= hwdata;
          `OFS_COMMAND: begin
            cmd_pulse <= 1'b1;
            cmd_code <= hwdata[7:0];
          end
          `OFS_START_LEVEL: start_level <= hwdata;
          `OFS_STOP_LEVEL: stop_level <= hwdata;
          `OFS_SAMPLE_LIMIT: sample_limit <= hwdata;
          `OFS_TIME_LIMIT: time_limit <= hwdata;
          `OFS_PERIOD_LIMIT: period_limit <= hwdata;
          `OFS_CAPTURE_TIME: capture_time <= hwdata;
          `OFS_REST_TIME: rest_time <= hwdata;
          `OFS_EXTENSION: extension <= hwdata;
          default: ;
        endcase
      end
    end
  end

  wire logic [31:0] status_word = {24'h0, in_rest, in_extension,
    card_ready, host_owns, mass_off, recording, session_active,
    power_up_done};

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0;
    end else if (addr_phase & ~hwrite) begin
      case (haddr)
        `OFS_CONFIG: hrdata <= config_reg;
        `OFS_START_LEVEL: hrdata <= start_level;
        `OFS_STOP_LEVEL: hrdata <= stop_level;
        `OFS_SAMPLE_LIMIT: hrdata <= sample_limit;
        `OFS_TIME_LIMIT: hrdata <= time_limit;
        `OFS_PERIOD_LIMIT: hrdata <= period_limit;
        `OFS_CAPTURE_TIME: hrdata <= capture_time;
        `OFS_REST_TIME: hrdata <= rest_time;
        `OFS_EXTENSION: hrdata <= extension;
        `OFS_STATUS: hrdata <= status_word;
        `OFS_SAMPLES: hrdata <= samples;
        `OFS_ELAPSED: hrdata <= elapsed;
        `OFS_FOLDER: hrdata <= folder_stamp;
        default: hrdata <= 32'h0;
      endcase
    end
  end

  // zero wait states, always okay
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  wire logic cmd_off = cmd_pulse & (cmd_code == `CMD_MASS_STORAGE_OFF);
  wire logic cmd_fmt = cmd_pulse & (cmd_code == `CMD_FORMAT_CARD);
  wire logic cmd_go = cmd_pulse & (cmd_code == `CMD_START_SESSION);
  wire logic cmd_end = cmd_pulse & (cmd_code == `CMD_STOP_SESSION);

  // ---------------------------------------------------------------
  // millisecond enable
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ms_div <= 32'h0;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= (ms_div == MS_CYCLES - 1);
      ms_div <= (ms_div == MS_CYCLES - 1) ? 32'h0 : ms_div + 32'h1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) uptime_ms <= 32'h0;
    else if (ms_tick) uptime_ms <= uptime_ms + 32'h1;
  end

  // ---------------------------------------------------------------
  // card ownership
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      usb_prev <= 1'b0;
      mass_off <= 1'b0;
    end else begin
      usb_prev <= usb_s;
      if (usb_s & ~usb_prev) mass_off <= 1'b0;
      else if (~usb_s) mass_off <= 1'b0;
      else if (cmd_off) mass_off <= 1'b1;
    end
  end
  assign host_owns = usb_s & ~mass_off;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) card_to_host <= 1'b0;
    else card_to_host <= host_owns;
  end

  // ---------------------------------------------------------------
  // card initialisation and indicator
  // ---------------------------------------------------------------
  logic init_seen;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      present_prev <= 1'b0;
      card_init_req <= 1'b0;
      card_format_req <= 1'b0;
      init_seen <= 1'b0;
    end else begin
      present_prev <= card_status.card_present;
      // power-on first cycle, or insertion edge; an insertion seen
      // right after reset is already covered by the power-on request
      card_init_req <= ~host_owns & ((~init_seen) |
        (card_status.card_present & ~present_prev &
        ~card_init_req));
      init_seen <= 1'b1;
      card_format_req <= cmd_fmt & ~host_owns &
        card_status.card_present;
    end
  end

  assign card_ready = card_status.card_present & card_status.init_done &
    card_status.init_ok;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) indicator <= '0;
    else begin
      indicator.blue_steady <= card_ready;
      indicator.red_pulse <= ~card_ready & uptime_ms[8];
    end
  end

  // ---------------------------------------------------------------
  // start and stop decisions
  // ---------------------------------------------------------------
  wire logic can_run = card_ready & ~host_owns;
  wire logic [1:0] rise = btn & ~btn_prev;

  function automatic logic btn_hit(input logic [1:0] sel_lr,
                                   input logic [1:0] b,
                                   input logic [1:0] r);
    // both: fires when both are down and one just went down
    btn_hit = (sel_lr == 2'b11) ? ((&b) & (|r)) : |(sel_lr & r);
  endfunction

  logic [1:0] start_btns, stop_btns;
  always_comb begin
    start_btns = 2'b00;
    stop_btns = 2'b00;
    case (start_src)
      start_left: start_btns = 2'b01;
      start_right: start_btns = 2'b10;
      start_both: start_btns = 2'b11;
      default: start_btns = 2'b00;
    endcase
    case (stop_src)
      stop_left: stop_btns = 2'b01;
      stop_right: stop_btns = 2'b10;
      stop_both: stop_btns = 2'b11;
      default: stop_btns = 2'b00;
    endcase
  end

  logic start_now;
  always_comb begin
    start_now = cmd_go;
    case (start_src)
      start_power_up: start_now = cmd_go | ~power_up_done;
      start_left, start_right, start_both:
        start_now = cmd_go | btn_hit(start_btns, btn, rise);
      start_motion: start_now = cmd_go | (motion.sample_tick &
        ({16'h0, motion.motion_mg} >= start_level));
      default: start_now = cmd_go;
    endcase
    start_now = start_now & can_run;
  end

  wire logic [31:0] next_samples = samples + 32'h1;
  logic stop_now;
  always_comb begin
    stop_now = cmd_end;
    case (stop_src)
      stop_immediate: stop_now = 1'b1;
      stop_left, stop_right, stop_both:
        stop_now = cmd_end | (stop_armed &
          btn_hit(stop_btns, btn, rise));
      stop_motion: stop_now = cmd_end | (motion.sample_tick &
        ({16'h0, motion.motion_mg} < stop_level));
      stop_samples: stop_now = cmd_end |
        (samples >= sample_limit);
      stop_duration: stop_now = cmd_end |
        (elapsed >= time_limit);
      stop_periods: stop_now = cmd_end |
        (periodic & (periods >= period_limit));
      default: stop_now = cmd_end;
    endcase
  end

  // ---------------------------------------------------------------
  // session state
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      session_active <= 1'b0;
      in_extension <= 1'b0;
      power_up_done <= 1'b0;
      stop_armed <= 1'b0;
      btn_prev <= 2'b00;
      folder_create_req <= 1'b0;
      folder_stamp <= 32'h0;
    end else begin
      btn_prev <= btn;
      folder_create_req <= 1'b0;
      if (can_run) power_up_done <= 1'b1;
      if (host_owns) begin
        session_active <= 1'b0;
        in_extension <= 1'b0;
      end else if (!session_active && !in_extension) begin
        if (start_now) begin
          session_active <= 1'b1;
          folder_create_req <= 1'b1;
          folder_stamp <= uptime_ms;
          // overlapping buttons still held must be released first
          stop_armed <= ~|(btn & start_btns & stop_btns);
        end
      end else if (session_active) begin
        if (~|(btn & stop_btns)) stop_armed <= 1'b1;
        if (stop_now) begin
          session_active <= 1'b0;
          in_extension <= (extension != 32'h0);
        end
      end else if (in_extension & ms_tick & (ext_ms + 32'h1 >= extension))
        in_extension <= 1'b0;
    end
  end

  wire logic session_start = start_now & ~session_active & ~in_extension
    & ~host_owns;

  // counters clear at start so every limit measures this session
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      samples <= 32'h0;
      elapsed <= 32'h0;
      periods <= 32'h0;
      phase_ms <= 32'h0;
      in_rest <= 1'b0;
      ext_ms <= 32'h0;
    end else if (session_start) begin
      samples <= 32'h0;
      elapsed <= 32'h0;
      periods <= 32'h0;
      phase_ms <= 32'h0;
      in_rest <= 1'b0;
      ext_ms <= 32'h0;
    end else begin
      if (recording & motion.sample_tick) samples <= next_samples;
      if (in_extension & ms_tick) ext_ms <= ext_ms + 32'h1;
      if (session_active & ms_tick) begin
        elapsed <= elapsed + 32'h1;
        if (periodic) begin
          if (!in_rest && phase_ms + 32'h1 >= capture_time) begin
            in_rest <= 1'b1;
            phase_ms <= 32'h0;
            periods <= periods + 32'h1;
          end else if (in_rest && phase_ms + 32'h1 >= rest_time) begin
            in_rest <= 1'b0;
            phase_ms <= 32'h0;
          end else phase_ms <= phase_ms + 32'h1;
        end else in_rest <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) recording <= 1'b0;
    else recording <= ~host_owns & ((session_active & ~in_rest) |
      in_extension);
  end

endmodule

// >>> tb/logging_session_control_sva.sv
// port assertions of the session controller
`timescale 1ns/1ps
module logging_session_control_sva (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // pins and card side
  input wire logic usb_attached,
  input wire logging_session_pkg::card_status_s card_status,
  // outputs watched
  input wire logic card_to_host,
  input wire logic card_init_req,
  input wire logic card_format_req,
  input wire logic folder_create_req,
  input wire logic recording,
  input wire logic session_active,
  input wire logging_session_pkg::indicator_s indicator
);
  import logging_session_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ---------------------------------------------------------------
  // session start steps
  // ---------------------------------------------------------------
  sequence start_s;
    $rose(session_active);
  endsequence
  sequence folder_s;
    folder_create_req || $past(folder_create_req);
  endsequence
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // two sync flops on the pin, so allow a few edges
  usb_owns_a: assert property (
    $rose(usb_attached) |-> ##[1:6] card_to_host)
    else $error("card not handed to host");
  host_quiet_a: assert property (
    card_to_host && $past(card_to_host, 2)
    |-> !recording && !session_active)
    else $error("logging while host owns card");
  usb_return_a: assert property (
    $fell(usb_attached) |-> ##[1:6] !card_to_host)
    else $error("card not returned on detach");
  start_owner_a: assert property (
    start_s |-> !card_to_host && indicator.blue_steady)
    else $error("session started without the card");
  blue_quiet_a: assert property (
    indicator.blue_steady && $past(indicator.blue_steady)
    |-> !indicator.red_pulse)
    else $error("red shown while card ready");
  folder_new_a: assert property (
    start_s |-> folder_s or ##1 folder_create_req)
    else $error("no folder for new session");
  record_follow_a: assert property (
    $rose(recording) |-> $past(session_active))
    else $error("recording outside a session");
  // after reset the power-on request may already cover the insertion
  insert_init_a: assert property (
    $rose(card_status.card_present) && !card_to_host
    |-> ##[0:8] card_init_req)
    else $error("no init on insertion");
  init_pulse_a: assert property (card_init_req |=> !card_init_req)
    else $error("init request longer than a pulse");
  format_card_a: assert property (
    card_format_req |-> card_status.card_present)
    else $error("format without a card");
endmodule

bind logging_session_control logging_session_control_sva sva_inst (
  .core_clk(core_clk), .rst(rst), .usb_attached(usb_attached),
  .card_status(card_status), .card_to_host(card_to_host),
  .card_init_req(card_init_req), .card_format_req(card_format_req),
  .folder_create_req(folder_create_req), .recording(recording),
  .session_active(session_active), .indicator(indicator));

// >>> tb/card_model.sv
// removable card model answering init and format requests
`timescale 1ns/1ps
module card_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // requests from the controller
  input wire logic card_init_req,
  input wire logic card_format_req,
  // bench control
  input wire logic inserted,
  // status back
  output logging_session_pkg::card_status_s card_status
);
  import logging_session_pkg::*;
  // a card keeps its format across a controller reset
  logic formatted = 1'h0;
  logic fmt;
  logic [3:0] busy;
  // answers slowly on purpose: nine cycles per request
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busy <= 4'h0;
      fmt <= 1'h0;
      card_status <= '0;
    end else if (!inserted) begin
      busy <= 4'h0;
      card_status <= '0;
    end else begin
      card_status.card_present <= 1'h1;
      card_status.card_formatted <= formatted;
      if (busy != 4'h0)
        busy <= busy - 4'h1;
      if (card_init_req || card_format_req) begin
        busy <= 4'h9;
        fmt <= card_format_req;
        card_status.init_done <= 1'h0;
        card_status.init_ok <= 1'h0;
      end else if (busy == 4'h1) begin
        if (fmt)
          formatted <= 1'h1;
        card_status.init_done <= 1'h1;
        card_status.init_ok <= formatted || fmt;
      end
    end
  end
endmodule

// >>> tb/test_logging_session_control.sv
// self-checking bench of the session controller
`timescale 1ns/1ps
`include "logging_session_control_regs.svh"
`define CHECK(got, exp) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    fails++; \
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
  end \
end

module test_logging_session_control;
  import logging_session_pkg::*;
  typedef struct {logic [15:0] cfg; int go; int halt; logic stay;} row_s;
  logic core_clk, rst, hsel, hwrite, usb_attached, inserted;
  logic button_left, button_right;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic hreadyout, hresp, card_to_host, card_init_req, card_format_req;
  logic folder_create_req, recording, session_active;
  motion_sample_s motion;
  card_status_s card_status;
  indicator_s indicator;
  int fails = 0;
  int samples_checked = 0;
  int folders = 0;
  // start cmd/left/right/both/motion, every stop source but immediate
  row_s rows[9] = '{'{16'h0000, 0, 1, 0}, '{16'h0032, 2, 3, 0},
    '{16'h0023, 3, 2, 0}, '{16'h0044, 4, 4, 0}, '{16'h0055, 5, 6, 0},
    '{16'h0060, 0, 7, 0}, '{16'h0070, 0, 8, 0}, '{16'h0180, 0, 8, 0},
    '{16'h0080, 0, 8, 1}};

  // ms shortened to 10 cycles to keep the run short
  logging_session_control #(.MS_CYCLES(10)) logging_session_control_inst (
    .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .usb_attached(usb_attached),
    .button_left(button_left), .button_right(button_right),
    .card_status(card_status), .motion(motion),
    .card_to_host(card_to_host), .card_init_req(card_init_req),
    .card_format_req(card_format_req),
    .folder_create_req(folder_create_req), .recording(recording),
    .session_active(session_active), .indicator(indicator));
  card_model card_model_inst (.core_clk(core_clk), .rst(rst),
    .card_init_req(card_init_req), .card_format_req(card_format_req),
    .inserted(inserted), .card_status(card_status));

  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
    if (folder_create_req === 1'h1)
      folders++;

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // single word transfer, called just after a rising edge
  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge core_clk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return session_active;
      1: return recording;
      2: return indicator.blue_steady;
      default: return card_to_host;
    endcase
  endfunction
  task automatic await(input int s, input logic v, input int n);
    for (int i = 0; i < n && pick(s) !== v; i++) cyc(1);
    `CHECK(pick(s), v)
  endtask
  task automatic press(input int k);
    button_left <= (k != 3);
    button_right <= (k != 2);
    cyc(20);
    button_left <= 1'h0;
    button_right <= 1'h0;
    cyc(10);
  endtask
  task automatic sample(input logic [15:0] lvl);
    motion <= '{1'h1, lvl};
    cyc(1);
    motion.sample_tick <= 1'h0;
    cyc(4);
  endtask
  task automatic act(input int k);
    case (k)
      0: bus(1'h1, `OFS_COMMAND, 32'h3C);
      1: bus(1'h1, `OFS_COMMAND, 32'h3D);
      2, 3, 4: press(k);
      5: sample(16'h01F4);
      6: sample(16'h012B);
      7: repeat (3) sample(16'h0200);
      default: cyc(80);
    endcase
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #400us;
    fails++;
    wrap_up();
  end

  initial begin
    int f0;
    rst = 1'h1;
    {hsel, hwrite, usb_attached, inserted} = 4'h0;
    {button_left, button_right} = 2'h0;
    haddr = 12'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    motion = '0;
    cyc(4);
    rst <= 1'h0;
    cyc(1);
    bus(1'h0, `OFS_CONFIG, 32'h0);
    `CHECK(rd, 32'h32)
    bus(1'h0, 12'h100, 32'h0);
    `CHECK(rd, 32'h0)
    // no card: starts refused, red pulses
    bus(1'h1, `OFS_CONFIG, 32'h1);
    act(0);
    cyc(20);
    `CHECK(session_active, 1'h0)
    rd[0] = indicator.red_pulse;
    for (int i = 0; i < 3000 && indicator.red_pulse === rd[0]; i++) cyc(1);
    `CHECK(indicator.red_pulse, ~rd[0])
    inserted <= 1'h1;
    cyc(40);
    `CHECK(indicator.blue_steady, 1'h0)
    bus(1'h1, `OFS_COMMAND, 32'h3B);
    await(2, 1'h1, 100);
    await(0, 1'h1, 100);
    act(1);
    await(0, 1'h0, 50);
    cyc(100);
    `CHECK(session_active, 1'h0)
    $display("card and power-up tests done");
    // usb attach aborts, mass storage off, detach
    bus(1'h1, `OFS_CONFIG, 32'h0);
    act(0);
    await(0, 1'h1, 50);
    usb_attached <= 1'h1;
    await(3, 1'h1, 50);
    await(0, 1'h0, 50);
    act(0);
    cyc(20);
    `CHECK(session_active, 1'h0)
    bus(1'h1, `OFS_COMMAND, 32'h3A);
    await(3, 1'h0, 50);
    act(0);
    await(0, 1'h1, 50);
    act(1);
    await(0, 1'h0, 50);
    usb_attached <= 1'h0;
    cyc(10);
    usb_attached <= 1'h1;
    await(3, 1'h1, 50);
    usb_attached <= 1'h0;
    await(3, 1'h0, 50);
    $display("usb tests done");
    bus(1'h1, `OFS_SAMPLE_LIMIT, 32'h3);
    bus(1'h1, `OFS_TIME_LIMIT, 32'h4);
    bus(1'h1, `OFS_CAPTURE_TIME, 32'h2);
    bus(1'h1, `OFS_REST_TIME, 32'h2);
    f0 = folders;
    foreach (rows[i]) begin
      bus(1'h1, `OFS_CONFIG, {16'h0, rows[i].cfg});
      act(rows[i].go);
      await(0, 1'h1, 100);
      act(rows[i].halt);
      await(0, rows[i].stay, 200);
      if (rows[i].stay)
        act(1);
      await(0, 1'h0, 50);
      $display("row %0d done", i);
    end
    `CHECK(folders - f0, 9)
    // immediate stop keeps only the extension
    bus(1'h1, `OFS_EXTENSION, 32'h3);
    bus(1'h1, `OFS_CONFIG, 32'h10);
    act(0);
    await(1, 1'h1, 50);
    cyc(5);
    `CHECK(session_active, 1'h0)
    `CHECK(recording, 1'h1)
    await(1, 1'h0, 60);
    $display("extension test done");
    // mid-run reset: outputs drop, power-on init finds the card ready
    rst <= 1'h1;
    cyc(2);
    `CHECK({session_active, recording, card_to_host, card_init_req}, 4'h0)
    `CHECK({hreadyout, hresp, indicator}, 4'h8)
    rst <= 1'h0;
    cyc(2);
    `CHECK(card_init_req, 1'h1)
    cyc(1);
    `CHECK(card_init_req, 1'h0)
    await(2, 1'h1, 50);
    $display("reset test done");
    wrap_up();
  end
endmodule
